/* File: rtl/fsp_ctrl.sv */
// flash self-programming controller top
`timescale 1ns/1ps
module fsp_ctrl #(
    parameter int PROG_CYCLES = fsp_pkg::PROG_CYC,
    parameter int PAGE_WORDS = 64,
    parameter int BOOT_FIRST_PAGE = 224
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core side
    input wire logic spm_exec,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] data_word,
    output logic cpu_stall,
    // lock programming from the external programmer
    input wire logic ext_lock_set,
    input wire logic [3:0] ext_lock_val,
    input wire logic chip_erase,
    // flash array side
    output logic flash_wr_stb,
    output logic [13:0] flash_wr_addr,
    output logic [15:0] flash_wr_data,
    output logic flash_erase_stb,
    output logic [7:0] flash_page,
    output logic flash_prog,
    // protection view and interrupt
    output logic [3:0] lock_bits,
    output logic irq
);
    // sequencer states
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_STREAM,
        FSP_BURN
    } fsp_state_t;

    // sequencer state
    fsp_state_t state_q;
    // command bits held in the control register
    logic [4:0] cmd_q;
    // read-enable bit, kept only for software compatibility
    logic read_en_q;
    // sticky events, mask, locks
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic [3:0] lock_q;
    // page being processed and word index while streaming
    logic [7:0] page_q;
    logic [5:0] idx_q;
    // read data register
    logic [7:0] rdata_q;
    // flash outputs
    logic wr_stb_q;
    logic [13:0] wr_addr_q;
    logic [15:0] wr_data_q;
    logic erase_stb_q;
    // temporary page buffer
    logic [15:0] buf_mem [PAGE_WORDS];

    // decoded strobes
    logic ctrl_wr;
    logic stat_rd;
    logic win_open;
    logic win_expire;
    logic fire;
    logic tmr_load;
    logic [15:0] tmr_count;
    logic tmr_busy;
    logic tmr_done;
    logic refuse;
    logic start_write;
    logic start_erase;
    logic start_lock;
    logic instant_done;
    logic [7:0] z_page;
    logic [2:0] events;

    // true when the page lies in the boot section
    function automatic logic in_boot(input logic [7:0] pg);
        in_boot = (pg >= 8'(BOOT_FIRST_PAGE));
    endfunction

    // true when the lock bits forbid touching the page
    function automatic logic guarded(input logic [7:0] pg,
                                     input logic [3:0] lk);
        if (in_boot(pg))
        begin
            guarded = |lk[3:2];
        end
        else
        begin
            guarded = |lk[1:0];
        end
    endfunction

    // register decode
    assign ctrl_wr = reg_wr && (reg_addr == fsp_pkg::ADDR_CTRL)
                     && (state_q == FSP_IDLE);
    assign stat_rd = reg_rd && (reg_addr == fsp_pkg::ADDR_STAT);

    assign z_page = z_ptr[fsp_pkg::PAGE_MSB:fsp_pkg::PAGE_LSB];

    assign fire = spm_exec && win_open && (state_q == FSP_IDLE)
                  && cmd_q[fsp_pkg::CTRL_ENABLE_BIT];

    assign refuse = fire && guarded(z_page, lock_q)
                    && ((cmd_q == fsp_pkg::CMD_WRITE)
                        || (cmd_q == fsp_pkg::CMD_ERASE));

    // operation starts
    assign start_write = fire && !refuse
                         && (cmd_q == fsp_pkg::CMD_WRITE);
    assign start_erase = fire && !refuse
                         && (cmd_q == fsp_pkg::CMD_ERASE);
    assign start_lock = fire && (cmd_q == fsp_pkg::CMD_LOCK);

    // buffer load and reenable finish at once
    assign instant_done = fire && !refuse && !start_write
                          && !start_erase && !start_lock;

    // programming pulse length for the timer
    assign tmr_load = start_erase || start_lock
                      || ((state_q == FSP_STREAM)
                          && (idx_q == 6'(PAGE_WORDS - 1)));
    assign tmr_count = start_lock ? 16'(fsp_pkg::LOCK_CYC)
                                  : 16'(PROG_CYCLES);

    // command window
    fsp_window #(
        .CYC(fsp_pkg::WINDOW_CYC)
    ) u_window (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .arm(ctrl_wr),
        .fire(fire),
        .open(win_open),
        .expire(win_expire)
    );

    // programming pulse timer
    fsp_timer #(
        .W(fsp_pkg::TMR_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .load(tmr_load),
        .count(tmr_count),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // sequencer: idle, stream buffer out, wait for pulse
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_q <= FSP_IDLE;
        end
        else if (clk_en)
        begin
            unique case (state_q)
                FSP_IDLE:
                begin
                    if (start_write)
                    begin
                        state_q <= FSP_STREAM;
                    end
                    else if (start_erase || start_lock)
                    begin
                        state_q <= FSP_BURN;
                    end
                end
                FSP_STREAM:
                begin
                    // last word sent, timer loaded
                    if (idx_q == 6'(PAGE_WORDS - 1))
                    begin
                        state_q <= FSP_BURN;
                    end
                end
                FSP_BURN:
                begin
                    if (tmr_done)
                    begin
                        state_q <= FSP_IDLE;
                    end
                end
            endcase
        end
    end

    // page and word index tracking
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            page_q <= 8'h00;
            idx_q <= 6'h00;
        end
        else if (clk_en)
        begin
            if (start_write || start_erase)
            begin
                page_q <= z_page;
                idx_q <= 6'h00;
            end
            else if (state_q == FSP_STREAM)
            begin
                idx_q <= idx_q + 6'h01;
            end
        end
    end

    // temporary buffer fill
    always_ff @(posedge clk_sys)
    begin
        if (clk_en && fire && (cmd_q == fsp_pkg::CMD_LOAD))
        begin
            buf_mem[z_ptr[fsp_pkg::WORD_MSB:fsp_pkg::WORD_LSB]]
                <= data_word;
        end
    end

    // flash write and erase strobes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wr_stb_q <= 1'b0;
            wr_addr_q <= 14'h0000;
            wr_data_q <= 16'h0000;
            erase_stb_q <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_stb_q <= (state_q == FSP_STREAM);
            erase_stb_q <= start_erase;
            if (state_q == FSP_STREAM)
            begin
                wr_addr_q <= {page_q, idx_q};
                wr_data_q <= buf_mem[idx_q];
            end
        end
    end

    // control register: command bits and read-enable
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cmd_q <= fsp_pkg::CTRL_RESET[4:0];
            read_en_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ctrl_wr)
            begin
                cmd_q <= reg_wdata[4:0];
            end
            else if (win_expire)
            begin
                cmd_q <= 5'h00;
            end
            else if (tmr_done || instant_done || refuse)
            begin
                cmd_q <= 5'h00;
            end
            if (fire && (cmd_q == fsp_pkg::CMD_REENABLE))
            begin
                read_en_q <= 1'b0;
            end
            else if (ctrl_wr)
            begin
                read_en_q <= reg_wdata[fsp_pkg::CTRL_READ_EN_BIT];
            end
        end
    end

    // lock bits: set by software or programmer, cleared by erase
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            lock_q <= fsp_pkg::LOCK_RESET;
        end
        else if (clk_en)
        begin
            if (chip_erase)
            begin
                lock_q <= fsp_pkg::LOCK_RESET;
            end
            else if (start_lock || ext_lock_set)
            begin
                lock_q <= lock_q
                          | (start_lock ? data_word[3:0] : 4'h0)
                          | (ext_lock_set ? ext_lock_val : 4'h0);
            end
        end
    end

    // events seen this cycle
    assign events = {win_expire, refuse, tmr_done || instant_done};

    // sticky status, cleared by reading, new events win
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            stat_q <= fsp_pkg::STAT_RESET;
        end
        else if (clk_en)
        begin
            stat_q <= (stat_rd ? 3'h0 : stat_q) | events;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            mask_q <= fsp_pkg::MASK_RESET;
        end
        else if (clk_en && reg_wr
                 && (reg_addr == fsp_pkg::ADDR_MASK))
        begin
            mask_q <= reg_wdata[2:0];
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rdata_q <= 8'h00;
        end
        else if (clk_en)
        begin
            if (reg_rd)
            begin
                unique case (reg_addr)
                    fsp_pkg::ADDR_CTRL:
                    begin
                        rdata_q <= {3'h0, read_en_q, cmd_q[3:0]};
                        rdata_q[fsp_pkg::CTRL_BUSY_BIT] <= 1'b0;
                        rdata_q[fsp_pkg::CTRL_ENABLE_BIT] <= cmd_q[0];
                    end
                    fsp_pkg::ADDR_STAT:
                    begin
                        rdata_q <= {5'h00, stat_q};
                    end
                    fsp_pkg::ADDR_MASK:
                    begin
                        rdata_q <= {5'h00, mask_q};
                    end
                    fsp_pkg::ADDR_LOCK:
                    begin
                        rdata_q <= {4'h0, lock_q};
                    end
                    default:
                    begin
                        // unmapped offsets read zero
                        rdata_q <= 8'h00;
                    end
                endcase
            end
            else
            begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign cpu_stall = (state_q != FSP_IDLE) || tmr_busy;

    // outputs
    assign reg_rdata = rdata_q;
    assign flash_wr_stb = wr_stb_q;
    assign flash_wr_addr = wr_addr_q;
    assign flash_wr_data = wr_data_q;
    assign flash_erase_stb = erase_stb_q;
    assign flash_page = page_q;
    assign flash_prog = (state_q == FSP_BURN);
    assign lock_bits = lock_q;
    // level interrupt from unmasked sticky bits
    assign irq = |(stat_q & mask_q);
endmodule // fsp_ctrl

/* File: rtl/fsp_pkg.sv */
// constants shared by the flash self-programming controller
package fsp_pkg;
    // register word offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_LOCK = 4'h3;
    // control register fields
    localparam int CMD_W = 5;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_READ_EN_BIT = 4;
    localparam int CTRL_BUSY_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // command codes in the low five control bits
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    // status and mask bits
    localparam int ST_DONE_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_EXPIRED_BIT = 2;
    localparam int ST_W = 3;
    localparam logic [2:0] STAT_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    // lock field layout: low pair guards application, high pair boot
    localparam int LOCK_W = 4;
    localparam logic [3:0] LOCK_RESET = 4'h0;
    // pointer fields
    localparam int PAGE_MSB = 14;
    localparam int PAGE_LSB = 7;
    localparam int WORD_MSB = 6;
    localparam int WORD_LSB = 1;
    // clock and timing
    localparam int CLK_HZ = 10000000;
    localparam int WINDOW_CYC = 4;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYC = (PROG_TIME_US * (CLK_HZ / 1000000));
    localparam int LOCK_TIME_US = 1;
    localparam int LOCK_CYC = (LOCK_TIME_US * (CLK_HZ / 1000000));
    localparam int TMR_W = 16;
endpackage

/* File: rtl/fsp_window.sv */
// four-cycle window between command write and store instruction
`timescale 1ns/1ps
module fsp_window #(
    parameter int CYC = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // arm and fire
    input wire logic arm,
    input wire logic fire,
    // window state
    output logic open,
    output logic expire
);
    // remaining cycles in which the instruction is accepted
    logic [2:0] cnt_q;

    assign open = (cnt_q != 3'h0);
    // last open cycle passed without the instruction
    assign expire = (cnt_q == 3'h1) && !fire && !arm;

    // count down, reload on every command write
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cnt_q <= 3'h0;
        end
        else if (clk_en)
        begin
            if (arm)
            begin
                cnt_q <= 3'(CYC);
            end
            else if (fire || !open)
            begin
                cnt_q <= 3'h0;
            end
            else
            begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule // fsp_window

/* File: rtl/fsp_timer.sv */
// one-shot countdown timing the flash programming pulse
`timescale 1ns/1ps
module fsp_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // load with a cycle count
    input wire logic load,
    input wire logic [W-1:0] count,
    // state
    output logic busy,
    output logic done
);
    // cycles still to run
    logic [W-1:0] cnt_q;

    assign busy = (cnt_q != '0);
    // one-cycle pulse as the last cycle ends
    assign done = (cnt_q == W'(1)) && clk_en;

    // load or count down
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (load)
            begin
                cnt_q <= count;
            end
            else if (busy)
            begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end
endmodule // fsp_timer

/* File: tb/fsp_ctrl_properties.sv */
// checker on the self-programming controller ports
`timescale 1ns/1ps
module fsp_ctrl_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // core side
    input wire logic spm_exec,
    input wire logic cpu_stall,
    // lock programming
    input wire logic ext_lock_set,
    input wire logic [3:0] ext_lock_val,
    input wire logic chip_erase,
    // flash side
    input wire logic flash_wr_stb,
    input wire logic [13:0] flash_wr_addr,
    input wire logic flash_erase_stb,
    input wire logic [7:0] flash_page,
    input wire logic flash_prog,
    // protection and interrupt
    input wire logic [3:0] lock_bits,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // page write code taken while idle and unprotected
    sequence s_wr_cmd;
        clk_en && reg_wr && reg_addr == fsp_pkg::ADDR_CTRL &&
            reg_wdata[4:0] == fsp_pkg::CMD_WRITE && !cpu_stall &&
            lock_bits == 4'h0;
    endsequence
    // store instruction on the very next cycle
    sequence s_spm;
        spm_exec && clk_en;
    endsequence
    property p_wr_start;
        s_wr_cmd ##1 s_spm |=> cpu_stall ##[0:2] flash_wr_stb;
    endproperty
    a_wr_start: assert property (p_wr_start)
        else $error("page write did not start");
    property p_burst;
        $rose(flash_wr_stb) |-> flash_wr_stb [*8];
    endproperty
    a_burst: assert property (p_burst)
        else $error("write stream broken");
    property p_page;
        flash_wr_stb |-> flash_wr_addr[13:6] == flash_page;
    endproperty
    a_page: assert property (p_page)
        else $error("word address outside page");
    property p_stall;
        flash_wr_stb || flash_prog |-> cpu_stall;
    endproperty
    a_stall: assert property (p_stall)
        else $error("core not stalled");
    property p_erase_stall;
        flash_erase_stb |-> ##[0:1] cpu_stall;
    endproperty
    a_erase_stall: assert property (p_erase_stall)
        else $error("erase without stall");
    property p_rdata_idle;
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_lock_keep;
        !$past(chip_erase) |->
            (lock_bits & $past(lock_bits)) == $past(lock_bits);
    endproperty
    a_lock_keep: assert property (p_lock_keep)
        else $error("lock bit cleared without erase");
    property p_ce_clear;
        clk_en && chip_erase |=> lock_bits == 4'h0;
    endproperty
    a_ce_clear: assert property (p_ce_clear)
        else $error("chip erase left lock bits");
    property p_ext_or;
        clk_en && ext_lock_set && !chip_erase |=>
            (lock_bits & $past(ext_lock_val)) == $past(ext_lock_val);
    endproperty
    a_ext_or: assert property (p_ext_or)
        else $error("external lock set lost");
    property p_irq_off;
        clk_en && reg_wr && reg_addr == fsp_pkg::ADDR_MASK &&
            reg_wdata[2:0] == 3'h0 |-> ##[1:2] !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("masked interrupt still high");
endmodule // fsp_ctrl_properties

bind fsp_ctrl fsp_ctrl_properties u_props (.clk_sys, .rst_b, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .spm_exec,
    .cpu_stall, .ext_lock_set, .ext_lock_val, .chip_erase, .flash_wr_stb,
    .flash_wr_addr, .flash_erase_stb, .flash_page, .flash_prog,
    .lock_bits, .irq);

/* File: tb/fsp_flash_model.sv */
// behavioural flash array catching the controller strobes
`timescale 1ns/1ps
module fsp_flash_model (
    // clock and run enable
    input wire logic clk_sys,
    input wire logic clk_en,
    // write stream
    input wire logic flash_wr_stb,
    input wire logic [13:0] flash_wr_addr,
    input wire logic [15:0] flash_wr_data,
    // erase and pulse
    input wire logic flash_erase_stb,
    input wire logic flash_prog
);
    logic [15:0] mem [64]; // page image by word index
    logic [7:0] wr_page = 8'h00; // page of last streamed word
    int n_wr = 0; // words streamed
    int n_er = 0; // erase strobes
    int n_prog = 0; // cycles of programming pulse
    // frozen cycles are not counted, the strobes only hold then
    always @(posedge clk_sys)
    begin
        if (clk_en === 1'b1)
        begin
            if (flash_wr_stb === 1'b1)
            begin
                mem[flash_wr_addr[5:0]] <= flash_wr_data;
                wr_page <= flash_wr_addr[13:6];
                n_wr <= n_wr + 1;
            end
            if (flash_erase_stb === 1'b1)
                n_er <= n_er + 1;
            if (flash_prog === 1'b1)
                n_prog <= n_prog + 1;
        end
    end
endmodule // fsp_flash_model

/* File: tb/fsp_ctrl_tb.sv */
// random and directed bench for the self-programming controller
`timescale 1ns/1ps
module fsp_ctrl_tb;
    logic clk_sys = 1'b0; // 10 MHz system clock
    logic rst_b = 1'b0; // reset, low active
    logic clk_en = 1'b1; // run enable
    // register port
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    // core side
    logic spm_exec = 1'b0;
    logic [15:0] z_ptr = 16'h0000;
    logic [15:0] data_word = 16'h0000;
    logic cpu_stall;
    // lock programming
    logic ext_lock_set = 1'b0;
    logic [3:0] ext_lock_val = 4'h0;
    logic chip_erase = 1'b0;
    // flash side and outputs
    logic flash_wr_stb, flash_erase_stb, flash_prog, irq;
    logic [13:0] flash_wr_addr;
    logic [15:0] flash_wr_data;
    logic [7:0] flash_page;
    logic [3:0] lock_bits;
    int miscompares = 0; // mismatches seen
    int n_checks = 0; // comparisons made
    logic [7:0] rd_v; // last read data
    logic [15:0] buf_v [64]; // words loaded into the buffer
    logic [7:0] pg, v; // page and scratch value
    logic [3:0] lk; // expected lock bits
    int np; // pulse count before an erase
    always #50 clk_sys = ~clk_sys;
    fsp_ctrl #(.PROG_CYCLES(20)) u_dut (.clk_sys, .rst_b, .clk_en,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .spm_exec,
        .z_ptr, .data_word, .cpu_stall, .ext_lock_set, .ext_lock_val,
        .chip_erase, .flash_wr_stb, .flash_wr_addr, .flash_wr_data,
        .flash_erase_stb, .flash_page, .flash_prog, .lock_bits, .irq);
    fsp_flash_model u_fl (.clk_sys, .clk_en, .flash_wr_stb,
        .flash_wr_addr, .flash_wr_data, .flash_erase_stb, .flash_prog);
    // compare and count
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // report counts and end the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one-cycle register write
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd_v = reg_rdata;
    endtask
    // command code, then the store instruction n cycles later
    task automatic run_cmd(input logic [4:0] c, input logic [15:0] z,
        input logic [15:0] d, input int n);
        wr_reg(fsp_pkg::ADDR_CTRL, {3'h0, c});
        z_ptr <= z;
        data_word <= d;
        repeat (n - 1) @(posedge clk_sys);
        spm_exec <= 1'b1;
        @(posedge clk_sys);
        spm_exec <= 1'b0;
    endtask
    // poll until the enable flag drops, bounded
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200; i++)
        begin
            rd_reg(fsp_pkg::ADDR_CTRL);
            if (rd_v[fsp_pkg::CTRL_ENABLE_BIT] === 1'b0)
                break;
        end
        if (i == 200)
        begin
            miscompares++;
            give_verdict();
        end
    endtask
    // hang guard
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(97789));
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        // reset values, unmapped places read zero
        for (int a = 0; a < 16; a++)
        begin
            rd_reg(4'(a));
            check("reset read", {8'h00, rd_v}, 16'h0000);
        end
        v = 8'($urandom);
        wr_reg(fsp_pkg::ADDR_MASK, v);
        wr_reg(fsp_pkg::ADDR_LOCK, 8'h0F);
        rd_reg(fsp_pkg::ADDR_MASK);
        check("mask", {13'h0, rd_v[2:0]}, {13'h0, v[2:0]});
        rd_reg(fsp_pkg::ADDR_LOCK);
        check("lock ro", {8'h00, rd_v}, 16'h0000);
        rd_reg(fsp_pkg::ADDR_STAT);
        wr_reg(fsp_pkg::ADDR_MASK, 8'h01);
        // buffer loads need no trailing words
        for (int i = 0; i < 64; i++)
        begin
            buf_v[i] = 16'($urandom);
            run_cmd(fsp_pkg::CMD_LOAD, {9'h000, 6'(i), 1'b0}, buf_v[i],
                1 + $urandom % 4);
            wait_idle();
            if (i == 0)
            begin
                check("irq set", {15'h0, irq}, 16'h0001);
                rd_reg(fsp_pkg::ADDR_STAT);
                check("done", {15'h0, rd_v[0]}, 16'h0001);
                check("irq clr", {15'h0, irq}, 16'h0000);
                wr_reg(fsp_pkg::ADDR_MASK, 8'h00);
            end
        end
        check("no write", 16'(u_fl.n_wr), 16'h0000);
        // page writes at every spacing, data word ignored
        // irq masked, ctrl polled
        for (int d = 1; d <= 4; d++)
        begin
            pg = 8'($urandom % 224);
            run_cmd(fsp_pkg::CMD_WRITE, {1'b0, pg, 7'h00}, 16'(~d), d);
            @(negedge clk_sys);
            check("stall", {15'h0, cpu_stall}, 16'h0001);
            wait_idle();
            check("words", 16'(u_fl.n_wr), 16'(64 * d));
            check("page", {8'h00, u_fl.wr_page}, {8'h00, pg});
            check("pulse", 16'(u_fl.n_prog), 16'(20 * d));
            for (int i = 0; i < 64 && d == 1; i++)
                check("word", u_fl.mem[i], buf_v[i]);
            repeat (2) @(posedge clk_sys);
        end
        rd_reg(fsp_pkg::ADDR_STAT);
        // command dropped when spm comes late
        run_cmd(fsp_pkg::CMD_WRITE, 16'h0080, 16'h0000, 6);
        @(negedge clk_sys);
        check("late stall", {15'h0, cpu_stall}, 16'h0000);
        rd_reg(fsp_pkg::ADDR_CTRL);
        check("late cmd", {11'h0, rd_v[4:0]}, 16'h0000);
        rd_reg(fsp_pkg::ADDR_STAT);
        check("expired", {15'h0, rd_v[2]}, 16'h0001);
        check("late words", 16'(u_fl.n_wr), 16'(256));
        // reenable leaves the busy bit clear
        run_cmd(fsp_pkg::CMD_REENABLE, 16'h0000, 16'h0000, 2);
        wait_idle();
        check("busy", {15'h0, rd_v[6]}, 16'h0000);
        // erase, frozen for a while mid-pulse
        np = u_fl.n_prog;
        run_cmd(fsp_pkg::CMD_ERASE, {1'b0, pg, 7'h00}, 16'h0000, 3);
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        check("frozen", {15'h0, cpu_stall}, 16'h0001);
        clk_en <= 1'b1;
        wait_idle();
        check("erases", 16'(u_fl.n_er), 16'h0001);
        check("erase pulse", 16'(u_fl.n_prog - np), 16'(20));
        // lock sets accumulate
        lk = 4'h0;
        for (int i = 0; i < 3; i++)
        begin
            v = 8'($urandom);
            run_cmd(fsp_pkg::CMD_LOCK, 16'h0000, {12'h000, v[3:0]},
                1 + $urandom % 4);
            wait_idle();
            lk = lk | v[3:0];
            rd_reg(fsp_pkg::ADDR_LOCK);
            check("lock sw", {12'h0, rd_v[3:0]}, {12'h0, lk});
        end
        run_cmd(fsp_pkg::CMD_ERASE, 16'h0000, 16'h0000, 1);
        rd_reg(fsp_pkg::ADDR_STAT);
        check("refused", {15'h0, rd_v[1]}, {15'h0, |lk[1:0]});
        v = 8'($urandom);
        @(posedge clk_sys);
        ext_lock_val <= v[3:0];
        ext_lock_set <= 1'b1;
        @(posedge clk_sys);
        ext_lock_set <= 1'b0;
        @(negedge clk_sys);
        check("lock ext", {12'h0, lock_bits}, {12'h0, lk | v[3:0]});
        @(posedge clk_sys);
        ext_lock_set <= 1'b1;
        chip_erase <= 1'b1;
        @(posedge clk_sys);
        ext_lock_set <= 1'b0;
        chip_erase <= 1'b0;
        @(negedge clk_sys);
        check("lock erase", {12'h0, lock_bits}, 16'h0000);
        @(posedge clk_sys);
        ext_lock_set <= 1'b1;
        @(posedge clk_sys);
        ext_lock_set <= 1'b0;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        check("lock reset", {12'h0, lock_bits}, 16'h0000);
        give_verdict();
    end
endmodule // fsp_ctrl_tb
